// [pwr_mon_pkg.sv]
/*
  Shared constants and carrier types of the power monitor result block.
  Assumes one clock domain and a register port driven by a serial bus engine.
*/
package pwr_mon_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0]  OFS_CONFIG = 8'h00; // Mode and averaging
  localparam logic [7:0]  OFS_SHUNT  = 8'h01; // Shunt voltage result
  localparam logic [7:0]  OFS_BUS    = 8'h02; // Bus voltage result
  localparam logic [7:0]  OFS_POWER  = 8'h03; // Power result
  localparam logic [7:0]  OFS_CURR   = 8'h04; // Current result
  localparam logic [7:0]  OFS_CAL    = 8'h05; // Calibration value
  localparam logic [7:0]  OFS_MASK   = 8'h06; // Alert mask/enable
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] CONFIG_RST = 16'h4127; // Continuous shunt and bus
  localparam logic [15:0] ZERO_RST   = 16'h0000; // Results, cal, mask
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SRST_BIT = 15; // Self-clearing soft reset
  localparam int AVG_LSB  = 9;  // Averaging code [11:9]
  localparam int CONT_BIT = 2;  // Mode top bit: continuous
  localparam int BUSM_BIT = 1;  // Mode: bus measured
  localparam int SHM_BIT  = 0;  // Mode: shunt measured
  localparam int SOL_BIT  = 15; // shunt_over_limit_en
  localparam int SUL_BIT  = 14; // shunt_under_limit_en
  localparam int BOL_BIT  = 13; // bus_over_limit_en
  localparam int BUL_BIT  = 12; // bus_under_limit_en
  localparam int POL_BIT  = 11; // power_over_limit_en
  localparam int CONV_DONE_ALERT_EN_BIT = 10; // conv_done_alert_en
  localparam int AFF_BIT  = 4;  // limit_alert_flag
  localparam int CONV_DONE_FLAG_BIT = 3;  // conv_done_flag
  localparam int OVF_BIT  = 2;  // math_overflow_flag
  localparam int ALERT_LEVEL_SEL_BIT = 1;  // alert_level_sel
  localparam int LEN_BIT  = 0;  // alert_hold_en
  localparam logic [15:0] MASK_WR = 16'hFC03; // Writable mask bits
  // ----------------------------------------
  // Arithmetic scaling
  // ----------------------------------------
  localparam int          CUR_SHIFT = 11;         // Current product scale
  localparam logic [31:0] POWER_DIV = 32'd20000;  // Power step is 25 current steps
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic        wr;    // Write strobe, one cycle
    logic        rd;    // Read strobe, one cycle
    logic [7:0]  addr;  // Register pointer
    logic [15:0] wdata; // Write word
  } reg_req_t;
  typedef struct packed {
    logic        shunt_valid; // Shunt sample done pulse
    logic        bus_valid;   // Bus sample done pulse
    logic [15:0] shunt;       // Signed shunt code
    logic [15:0] bus;         // Bus code, low 15 bits used
  } sample_t;
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_shunt = 4'b0010,
    st_bus   = 4'b0100,
    st_math  = 4'b1000
  } seq_state_t;
endpackage

// [power_monitor_result_registers.sv]
/*
  Result, calibration and alert mask registers of a current/power monitor,
  with the conversion sequencer, averaging and derived-value arithmetic.
  Assumes a serial bus engine issuing one-cycle register strobes, a converter
  answering start pulses with sample pulses, and the alert limit as an input.
*/
// How it works
// - Top mode bit low: triggered measurements; 0 off
// - Top mode bit high: continuous; code 4 off
// - Shunt result is signed 16-bit two's complement
// - Shunt step 2.5 uV, 7FFF full scale
// - Bus step 1.25 mV, 7FFF full scale
// - Bus result bit 15 always reads zero
// - Bus result holds latest completed bus conversion
// - Results show averaged values when averaging enabled
// - Power step is 25 current steps
// - Power is current times bus voltage
// - Current is shunt times calibration value
// - Calibration is 15 bits, bit 15 unused
// - Highest enabled limit function alone is compared
// - Mask layout: enables, reserved, flags, polarity, latch
// - Enabled limit asserts alert beyond limit value
// - Ready flag sets after math; clears per rules
// - Overflow flag marks invalid current and power
// - Zero calibration gives zero current and power
`timescale 1ns/1ps
module power_monitor_result_registers
  import pwr_mon_pkg::*;
(
  input  wire logic        clk,         // 125 MHz clock
  input  wire logic        rst,         // Synchronous reset, high
  input  wire reg_req_t    req,         // Register strobes
  input  wire sample_t     sample,      // Converter results
  input  wire logic [15:0] alert_limit, // Limit compare value
  output logic      [15:0] reg_rdata,   // Read word
  output logic             shunt_start, // Start shunt conversion
  output logic             bus_start,   // Start bus conversion
  output logic             alert_pin    // Alert level
);
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic        [15:0] cfg;            // Configuration
  logic signed [15:0] shunt_result;   // Signed shunt code
  logic        [15:0] bus_result;     // Bus code
  logic        [15:0] power_result;   // Power code
  logic signed [15:0] current_result; // Signed current code
  logic        [15:0] cal;            // Calibration value
  logic        [15:0] mask;           // Mask/enable
  seq_state_t         state;          // Sequencer state
  seq_state_t         next_state;     // Sequencer next state
  logic               next_sh_start;  // Next shunt start pulse
  logic               next_bus_start; // Next bus start pulse
  logic signed [25:0] acc_shunt;      // Shunt sum
  logic        [24:0] acc_bus;        // Bus sum
  logic        [9:0]  avg_cnt;        // Samples taken
  logic        [9:0]  avg_last;       // Last sample index
  logic        [3:0]  avg_sh;         // Divide shift
  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic soft_rst;   // Soft reset write
  logic do_rst;     // Any reset
  logic cfg_wr;     // Config write
  logic mask_rd;    // Mask register read
  logic go;         // Start of a measurement cycle
  logic trig_mode;  // Triggered mode active
  assign soft_rst  = req.wr && req.addr == OFS_CONFIG && req.wdata[SRST_BIT];
  assign do_rst    = rst || soft_rst;
  assign cfg_wr    = req.wr && req.addr == OFS_CONFIG && !req.wdata[SRST_BIT];
  assign mask_rd   = req.rd && req.addr == OFS_MASK;
  assign trig_mode = !cfg[CONT_BIT];
  // New cycle on config write with a measuring mode
  assign go = cfg_wr && (req.wdata[BUSM_BIT] || req.wdata[SHM_BIT]);
  // ----------------------------------------
  // Averaging count decode
  // ----------------------------------------
  // Sample count and divide shift from the averaging code
  always_comb begin
    case (cfg[AVG_LSB +: 3])
      3'd0:    avg_sh = 4'd0;
      3'd1:    avg_sh = 4'd2;
      3'd2:    avg_sh = 4'd4;
      3'd3:    avg_sh = 4'd6;
      3'd4:    avg_sh = 4'd7;
      3'd5:    avg_sh = 4'd8;
      3'd6:    avg_sh = 4'd9;
      default: avg_sh = 4'd10;
    endcase
    avg_last = 10'((11'd1 << avg_sh) - 11'd1);
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Steps shunt then bus conversions, repeated per average
  always_comb begin
    next_state     = state;
    next_sh_start  = 1'b0;
    next_bus_start = 1'b0;
    case (state)
      st_idle: begin
        if (go) begin
          // Mode bits decide which conversion runs first
          if (req.wdata[SHM_BIT]) begin
            next_state    = st_shunt;
            next_sh_start = 1'b1;
          end else begin
            next_state     = st_bus;
            next_bus_start = 1'b1;
          end
        end
      end
      st_shunt: begin
        if (sample.shunt_valid) begin
          if (cfg[BUSM_BIT]) begin
            next_state     = st_bus;
            next_bus_start = 1'b1;
          end else if (avg_cnt == avg_last) begin
            next_state = st_math;
          end else begin
            next_sh_start = 1'b1;
          end
        end
      end
      st_bus: begin
        if (sample.bus_valid) begin
          if (avg_cnt == avg_last) begin
            next_state = st_math;
          end else if (cfg[SHM_BIT]) begin
            next_state    = st_shunt;
            next_sh_start = 1'b1;
          end else begin
            next_bus_start = 1'b1;
          end
        end
      end
      default: begin
        // Continuous modes start the next cycle at once
        if (!trig_mode && cfg[SHM_BIT]) begin
          next_state    = st_shunt;
          next_sh_start = 1'b1;
        end else if (!trig_mode && cfg[BUSM_BIT]) begin
          next_state     = st_bus;
          next_bus_start = 1'b1;
        end else begin
          next_state = st_idle;
        end
      end
    endcase
    // A config write halts and restarts the sequence
    if (cfg_wr && state != st_idle) begin
      next_state     = go ? (req.wdata[SHM_BIT] ? st_shunt : st_bus) : st_idle;
      next_sh_start  = go && req.wdata[SHM_BIT];
      next_bus_start = go && !req.wdata[SHM_BIT];
    end
  end
  // State and start pulses
  always_ff @(posedge clk) begin
    if (do_rst) begin
      state       <= st_idle;
      shunt_start <= 1'b0;
      bus_start   <= 1'b0;
    end else begin
      state       <= next_state;
      shunt_start <= next_sh_start;
      bus_start   <= next_bus_start;
    end
  end
  // ----------------------------------------
  // Accumulators
  // ----------------------------------------
  logic cycle_end; // One shunt+bus round finished
  assign cycle_end = (state == st_bus && sample.bus_valid)
                  || (state == st_shunt && sample.shunt_valid && !cfg[BUSM_BIT]);
  // Sums samples for averaging; cleared at every restart
  always_ff @(posedge clk) begin
    if (do_rst || cfg_wr || state == st_idle || state == st_math) begin
      acc_shunt <= '0;
      acc_bus   <= '0;
      avg_cnt   <= '0;
    end else begin
      if (state == st_shunt && sample.shunt_valid) begin
        acc_shunt <= acc_shunt + 26'(sample.shunt[15] ? {10'h3FF, sample.shunt}
                                                     : {10'h000, sample.shunt});
      end
      if (state == st_bus && sample.bus_valid) begin
        acc_bus <= acc_bus + {10'h000, sample.bus[14:0]};
      end
      if (cycle_end) begin
        avg_cnt <= avg_cnt + 10'd1;
      end
    end
  end
  // ----------------------------------------
  // Derived arithmetic
  // ----------------------------------------
  logic signed [15:0] shunt_new; // Averaged or held shunt
  logic        [15:0] bus_new;   // Averaged or held bus
  logic signed [31:0] cur_wide;  // Shunt times calibration
  logic signed [31:0] cur_scl;   // Scaled current
  logic               ovf_now;   // Current out of range
  logic signed [15:0] cur_new;   // Saturated current
  logic        [15:0] cur_abs;   // Current magnitude
  logic        [31:0] pw_wide;   // Power after scaling, before truncation
  logic        [15:0] pw_new;    // Power code
  logic               limit_hit; // Selected limit exceeded
  // Results, current and power from the averaged samples
  always_comb begin
    shunt_new = cfg[SHM_BIT] ? 16'(acc_shunt >>> avg_sh) : shunt_result;
    bus_new   = cfg[BUSM_BIT] ? {1'b0, 15'(acc_bus >> avg_sh)} : bus_result;
    cur_wide  = shunt_new * $signed({1'b0, cal[14:0]});
    cur_scl   = cur_wide >>> CUR_SHIFT;
    ovf_now   = cur_scl > 32'sd32767 || cur_scl < -32'sd32768;
    if (cur_scl > 32'sd32767) begin
      cur_new = 16'sh7FFF;
    end else if (cur_scl < -32'sd32768) begin
      cur_new = -16'sh7FFF - 16'sh0001;
    end else begin
      cur_new = 16'(cur_scl);
    end
    cur_abs = cur_new[15] ? 16'(-cur_new) : 16'(cur_new);
    pw_wide = ({16'h0000, cur_abs} * {16'h0000, bus_new}) / POWER_DIV;
    pw_new  = 16'(pw_wide);
    // Highest enabled limit function wins
    if (mask[SOL_BIT]) begin
      limit_hit = shunt_new > $signed(alert_limit);
    end else if (mask[SUL_BIT]) begin
      limit_hit = shunt_new < $signed(alert_limit);
    end else if (mask[BOL_BIT]) begin
      limit_hit = bus_new > alert_limit;
    end else if (mask[BUL_BIT]) begin
      limit_hit = bus_new < alert_limit;
    end else if (mask[POL_BIT]) begin
      limit_hit = pw_new > alert_limit;
    end else begin
      limit_hit = 1'b0;
    end
  end
  // ----------------------------------------
  // Result registers
  // ----------------------------------------
  // All results change together at the end of the math step
  always_ff @(posedge clk) begin
    if (do_rst) begin
      shunt_result   <= ZERO_RST;
      bus_result     <= ZERO_RST;
      current_result <= ZERO_RST;
      power_result   <= ZERO_RST;
    end else if (state == st_math) begin
      shunt_result   <= shunt_new;
      bus_result     <= bus_new;
      current_result <= cur_new;
      power_result   <= pw_new;
    end
  end
  // ----------------------------------------
  // Host-written registers
  // ----------------------------------------
  // Configuration and calibration registers
  always_ff @(posedge clk) begin
    if (do_rst) begin
      cfg <= CONFIG_RST;
      cal <= ZERO_RST;
    end else if (req.wr) begin
      if (req.addr == OFS_CONFIG) begin
        cfg <= {4'h4, req.wdata[11:0]};
      end else if (req.addr == OFS_CAL) begin
        cal <= {1'b0, req.wdata[14:0]};
      end
    end
  end
  // Mask: writable controls plus hardware flags
  always_ff @(posedge clk) begin
    if (do_rst) begin
      mask <= ZERO_RST;
    end else begin
      if (req.wr && req.addr == OFS_MASK) begin
        mask <= (mask & ~MASK_WR) | (req.wdata & MASK_WR);
      end
      // Ready flag: set wins over either clear
      if (state == st_math) begin
        mask[CONV_DONE_FLAG_BIT] <= 1'b1;
      end else if (trig_mode && (go || mask_rd)) begin
        mask[CONV_DONE_FLAG_BIT] <= 1'b0;
      end
      // Alert flag: latched clears on read, transparent on clean result
      if (state == st_math && limit_hit) begin
        mask[AFF_BIT] <= 1'b1;
      end else if (state == st_math && !mask[LEN_BIT]) begin
        mask[AFF_BIT] <= 1'b0;
      end else if (mask_rd && mask[LEN_BIT]) begin
        mask[AFF_BIT] <= 1'b0;
      end
      // Overflow flag follows each math step
      if (state == st_math) begin
        mask[OVF_BIT] <= ovf_now;
      end
    end
  end
  // ----------------------------------------
  // Read port and alert
  // ----------------------------------------
  // Registered read word; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (do_rst) begin
      reg_rdata <= ZERO_RST;
    end else if (req.rd) begin
      if (req.addr == OFS_CONFIG) begin
        reg_rdata <= cfg;
      end else if (req.addr == OFS_SHUNT) begin
        reg_rdata <= shunt_result;
      end else if (req.addr == OFS_BUS) begin
        reg_rdata <= bus_result;
      end else if (req.addr == OFS_POWER) begin
        reg_rdata <= power_result;
      end else if (req.addr == OFS_CURR) begin
        reg_rdata <= current_result;
      end else if (req.addr == OFS_CAL) begin
        reg_rdata <= cal;
      end else if (req.addr == OFS_MASK) begin
        reg_rdata <= mask;
      end else begin
        reg_rdata <= ZERO_RST;
      end
    end
  end
  // Alert level; low active unless polarity bit set
  always_ff @(posedge clk) begin
    if (do_rst) begin
      alert_pin <= 1'b1;
    end else begin
      alert_pin <= mask[ALERT_LEVEL_SEL_BIT] ~^ (mask[AFF_BIT]
                   || (mask[CONV_DONE_ALERT_EN_BIT] && mask[CONV_DONE_FLAG_BIT]));
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || soft_rst);
  a_bus_msb_zero: assert property (bus_result[15] == 1'b0)
    else $error("bus result sign bit set");
  a_cal_msb_zero: assert property (cal[15] == 1'b0)
    else $error("calibration bit 15 set");
  a_mask_rsvd_zero: assert property (mask[9:5] == 5'h00)
    else $error("mask reserved bits set");
  a_powerdown_quiet: assert property (cfg[1:0] == 2'b00 && !cfg_wr |=>
    !shunt_start && !bus_start) else $error("start pulse in power-down");
  a_trig_stops: assert property (state == st_math && trig_mode && !cfg_wr
    |=> state == st_idle) else $error("triggered mode did not stop");
  a_cont_restarts: assert property (state == st_math && !trig_mode
    && cfg[1:0] != 2'b00 && !cfg_wr |=> state != st_idle)
    else $error("continuous mode stopped");
  a_ready_sets: assert property (state == st_math |=> mask[CONV_DONE_FLAG_BIT])
    else $error("ready flag not set after math");
  a_results_hold: assert property (state != st_math |=>
    $stable(current_result) && $stable(power_result))
    else $error("result changed outside math step");
  a_cal_zero_out: assert property (state == st_math && cal == ZERO_RST
    |=> current_result == 16'sh0000 && power_result == ZERO_RST)
    else $error("nonzero result with zero calibration");
  a_ovf_flags: assert property (state == st_math && ovf_now
    |=> mask[OVF_BIT]) else $error("overflow not flagged");
  a_sol_priority: assert property (state == st_math && mask[SOL_BIT]
    && shunt_new > $signed(alert_limit) |=> mask[AFF_BIT])
    else $error("shunt over limit not flagged");
  c_trig_done: cover property (trig_mode && state == st_math ##1 state == st_idle);
  c_cont_loop: cover property (!trig_mode && state == st_math ##1 state == st_shunt);
  c_limit_alert: cover property (state == st_math && limit_hit);
endmodule

// [conv_model.sv]
/*
  Converter stand-in for the power monitor block: answers the latest start pulse
  with one sample pulse after a chosen delay.
  Assumes the block's registered start pulses and a single clock.
*/
`timescale 1ns/1ps
module conv_model
  import pwr_mon_pkg::*;
(
  input  wire logic        clk,         // Shared clock
  input  wire logic        rst,         // Synchronous reset, high
  input  wire logic        shunt_start, // Start shunt conversion
  input  wire logic        bus_start,   // Start bus conversion
  input  wire logic [15:0] shunt_base,  // Shunt code to report
  input  wire logic [15:0] bus_base,    // Bus code to report
  input  wire logic        ramp_en,     // Add a 0..3 ramp to each code
  input  wire logic [7:0]  delay,       // Cycles from start to sample, minus one
  output sample_t          sample,      // Sample pulses and codes
  output int               count        // Samples delivered so far
);
  // ----------------------------------------
  // Conversion engine
  // ----------------------------------------
  logic [7:0] wait_cnt; // Cycles left on the pending conversion
  logic       busy;     // A conversion is pending
  logic       kind;     // Pending kind: 0 shunt, 1 bus
  logic [1:0] step_s;   // Shunt ramp offset
  logic [1:0] step_b;   // Bus ramp offset
  // One pending conversion; a new start replaces it, as a restart would
  always_ff @(posedge clk) begin
    sample.shunt_valid <= 1'b0;
    sample.bus_valid   <= 1'b0;
    // Lines between samples toggle each cycle between the code and its inverse
    sample.shunt       <= ~sample.shunt;
    sample.bus         <= ~sample.bus;
    if (rst) begin
      busy   <= 1'b0;
      count  <= 0;
      step_s <= 2'd0;
      step_b <= 2'd0;
    end else if (shunt_start || bus_start) begin
      busy     <= 1'b1;
      kind     <= bus_start;
      wait_cnt <= delay;
    end else if (busy && wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end else if (busy) begin
      busy  <= 1'b0;
      count <= count + 1;
      if (kind) begin
        sample.bus_valid <= 1'b1;
        sample.bus       <= bus_base + (ramp_en ? {14'h0000, step_b} : 16'h0000);
        step_b           <= step_b + 2'd1;
      end else begin
        sample.shunt_valid <= 1'b1;
        sample.shunt       <= shunt_base + (ramp_en ? {14'h0000, step_s} : 16'h0000);
        step_s             <= step_s + 2'd1;
      end
    end
  end
endmodule

// [test_power_monitor_result_registers.sv]
/*
  Self-checking bench for the power monitor result registers.
  Assumes conv_model as converter and one 125 MHz clock.
*/
`timescale 1ns/1ps
module test_power_monitor_result_registers;
  import pwr_mon_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk;
  logic        rst;
  reg_req_t    req;         // Register strobes
  sample_t     sample;      // Converter samples
  logic [15:0] alert_limit; // Limit compare value
  logic [15:0] reg_rdata;   // Read word
  logic        shunt_start; // Shunt start pulse
  logic        bus_start;   // Bus start pulse
  logic        alert_pin;   // Alert level
  logic [15:0] shunt_base;  // Model shunt code
  logic [15:0] bus_base;    // Model bus code
  logic        ramp_en;     // Model ramp
  logic [7:0]  delay;       // Model latency
  int          count;       // Samples delivered
  int          n_sh;        // Shunt starts seen
  int          n_bu;        // Bus starts seen
  int          mismatches;
  int          tests_run;
  power_monitor_result_registers DUT (.clk(clk), .rst(rst), .req(req), .sample(sample),
    .alert_limit(alert_limit), .reg_rdata(reg_rdata), .shunt_start(shunt_start),
    .bus_start(bus_start), .alert_pin(alert_pin));
  conv_model conv (.clk(clk), .rst(rst), .shunt_start(shunt_start), .bus_start(bus_start),
    .shunt_base(shunt_base), .bus_base(bus_base), .ramp_en(ramp_en), .delay(delay),
    .sample(sample), .count(count));
  // Clock and start counters
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (rst) begin
      n_sh <= 0;
      n_bu <= 0;
    end else begin
      n_sh <= n_sh + int'(shunt_start === 1'b1);
      n_bu <= n_bu + int'(bus_start === 1'b1);
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge clk);
    req.wr    = 1'b0;
  endtask
  // Read word is registered at the taking edge
  task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd   = 1'b0;
    d        = reg_rdata;
  endtask
  // Bounded wait for n samples, then the math step lands
  task automatic run_cfg(input logic [15:0] cfg, input int n);
    int target;
    int i;
    target = count + n;
    reg_wr(OFS_CONFIG, cfg);
    for (i = 0; i < 3000 && count < target; i++) @(negedge clk);
    if (count < target) begin
      mismatches++;
      $display("CHECK FAILED at %0t: conversion never finished", $time);
      report_and_stop();
    end
    repeat (3) @(negedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    logic [7:0]  a;
    for (int i = 0; i < 9; i++) begin
      a = (i == 8) ? 8'h20 : 8'(i);
      reg_rd(a, d);
      check(d, (i == 0) ? CONFIG_RST : 16'h0000);
    end
    check({15'h0000, alert_pin}, 16'h0001);
  endtask
  task automatic t_access();
    logic [15:0] d;
    reg_wr(OFS_CAL, 16'hFFFF);
    reg_rd(OFS_CAL, d);
    check(d, 16'h7FFF);
    // Soft reset through the config word returns calibration to zero
    reg_wr(OFS_CONFIG, 16'h8000);
    reg_rd(OFS_CAL, d);
    check(d, 16'h0000);
    reg_wr(OFS_SHUNT, 16'h1234);
    reg_rd(OFS_SHUNT, d);
    check(d, 16'h0000);
    reg_wr(OFS_MASK, 16'hFFFF);
    reg_rd(OFS_MASK, d);
    check(d & 16'hFFE3, 16'hFC03);
    reg_wr(OFS_MASK, 16'h0000);
  endtask
  task automatic t_trig();
    logic [15:0] d;
    shunt_base = 16'h8300;
    bus_base   = 16'hFFFF;
    reg_wr(OFS_CAL, 16'h0000);
    run_cfg(16'h0003, 2);
    reg_rd(OFS_SHUNT, d);
    check(d, 16'h8300);
    reg_rd(OFS_BUS, d);
    check(d, 16'h7FFF);
    reg_rd(OFS_CURR, d);
    check(d, 16'h0000);
    reg_rd(OFS_MASK, d);
    check(d & 16'h0008, 16'h0008);
    reg_rd(OFS_MASK, d);
    check(d & 16'h0008, 16'h0000);
    // Slow converter, new bus code, live calibration
    delay    = 8'd20;
    bus_base = 16'h1234;
    reg_wr(OFS_CAL, 16'h0800);
    run_cfg(16'h0003, 2);
    reg_rd(OFS_BUS, d);
    check(d, 16'h1234);
    reg_rd(OFS_CURR, d);
    check(d, 16'h8300);
    reg_rd(OFS_POWER, d);
    check(d, 16'h1D20);
    delay = 8'd4;
  endtask
  // Four samples each: base, base+1, base+2, base+3 in some order
  task automatic t_avg();
    logic [15:0] d;
    ramp_en    = 1'b1;
    shunt_base = 16'hFFF0;
    bus_base   = 16'h0100;
    run_cfg(16'h0203, 8);
    reg_rd(OFS_SHUNT, d);
    check(d, 16'hFFF1);
    reg_rd(OFS_BUS, d);
    check(d, 16'h0101);
    reg_rd(OFS_CURR, d);
    check(d, 16'hFFF1);
    ramp_en = 1'b0;
  endtask
  task automatic t_ovf();
    logic [15:0] d;
    shunt_base = 16'h7FFF;
    reg_wr(OFS_CAL, 16'h7FFF);
    run_cfg(16'h0001, 1);
    reg_rd(OFS_CURR, d);
    check(d, 16'h7FFF);
    reg_rd(OFS_MASK, d);
    check(d & 16'h0004, 16'h0004);
  endtask
  // Shunt below limit, bus below limit: only the top enable counts
  task automatic t_alert();
    logic [15:0] d;
    shunt_base  = 16'h0064;
    bus_base    = 16'h0032;
    alert_limit = 16'h00C8;
    reg_wr(OFS_MASK, 16'h9000);
    run_cfg(16'h0003, 2);
    reg_rd(OFS_MASK, d);
    check(d & 16'h0010, 16'h0000);
    reg_wr(OFS_MASK, 16'h1000);
    run_cfg(16'h0003, 2);
    reg_rd(OFS_MASK, d);
    check(d & 16'h0010, 16'h0010);
    check({15'h0000, alert_pin}, 16'h0000);
    reg_wr(OFS_MASK, 16'h0000);
  endtask
  // Every mode code: which starts occur, once or repeatedly
  task automatic t_modes();
    int s0;
    int b0;
    logic [2:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      reg_wr(OFS_CONFIG, {13'h0000, m});
      s0 = n_sh;
      b0 = n_bu;
      repeat (300) @(negedge clk);
      check(16'(m[0] ? (m[2] ? n_sh - s0 > 1 : n_sh - s0 == 1) : n_sh == s0), 16'h0001);
      check(16'(m[1] ? (m[2] ? n_bu - b0 > 1 : n_bu - b0 == 1) : n_bu == b0), 16'h0001);
    end
    reg_wr(OFS_CONFIG, 16'h0000);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    req         = '0;
    alert_limit = 16'h0000;
    shunt_base  = 16'h0000;
    bus_base    = 16'h0000;
    ramp_en     = 1'b0;
    delay       = 8'd4;
    mismatches  = 0;
    tests_run   = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_access();
    t_trig();
    t_avg();
    t_ovf();
    t_alert();
    t_modes();
    report_and_stop();
  end
endmodule
